//--- common/mms_pkg.sv
// Shared constants and carrier types of the module management controller
package mms_pkg;

	// ==================================================================
	// Clock and timing
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned CNT_W           = 28;
	localparam int unsigned T_RESET_MIN_US  = 2;
	localparam int unsigned T_INIT_MS       = 2000;
	localparam int unsigned T_LP_ON_US      = 100;
	localparam int unsigned T_LP_OFF_MS     = 300;
	localparam int unsigned T_PD_ON_MS      = 100;
	localparam int unsigned T_PD_OFF_MS     = 300;
	localparam int unsigned T_RATESEL_US    = 100;
	localparam int unsigned RESET_MIN_CYC   = T_RESET_MIN_US * CLK_MHZ;
	localparam int unsigned INIT_CYC        = T_INIT_MS * 1000 * CLK_MHZ;
	localparam int unsigned LP_ON_CYC       = T_LP_ON_US * CLK_MHZ;
	localparam int unsigned LP_OFF_CYC      = T_LP_OFF_MS * 1000 * CLK_MHZ;
	localparam int unsigned PD_ON_CYC       = T_PD_ON_MS * 1000 * CLK_MHZ;
	localparam int unsigned PD_OFF_CYC      = T_PD_OFF_MS * 1000 * CLK_MHZ;
	localparam int unsigned RATESEL_CYC     = T_RATESEL_US * CLK_MHZ;
	localparam int unsigned RST_CNT_W       = 8;

	// ==================================================================
	// Register map (byte addresses)
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  ADDR_STATUS     = 8'h00;
	localparam logic [7:0]  ADDR_FLAGS      = 8'h04;
	localparam logic [7:0]  ADDR_MASK       = 8'h08;
	localparam logic [7:0]  ADDR_CONTROL    = 8'h0C;

	// STATUS fields
	localparam int unsigned ST_DNR          = 0;
	localparam int unsigned ST_FUNC         = 1;
	localparam int unsigned ST_LOWPWR       = 2;
	localparam int unsigned ST_RATEBUSY     = 3;
	localparam int unsigned ST_BUSRDY       = 4;

	// FLAGS / MASK layout
	localparam int unsigned LANES           = 4;
	localparam int unsigned FLG_W           = 9;
	localparam int unsigned FLG_READY       = 0;
	localparam int unsigned FLG_LOS_LSB     = 1;
	localparam int unsigned FLG_TXF_LSB     = 5;
	localparam logic [FLG_W-1:0] MASK_RST   = 9'h000;

	// CONTROL fields
	localparam int unsigned CTL_PDOWN       = 0;
	localparam int unsigned CTL_RATE_LSB    = 1;
	localparam int unsigned RATE_W          = 4;

	// ==================================================================
	// Two-wire management address, 8-bit form 1010000x
	localparam logic [6:0]  DEV_ADDR7       = 7'h50;
	localparam logic [2:0]  LAST_BIT        = 3'h7;

	// ==================================================================
	// Carriers
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0]       pwdata;
	} mms_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} mms_apb_rsp_t;

endpackage : mms_pkg

//--- design/mms_ctrl.sv
// Management control, status sequencing and interrupt logic of the optical module
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Reset pin low longer than 2 us is a reset request.
// - Module is fully functional within 2000 ms after power-on or reset release.
// - Two-wire bus answers no later than 2000 ms after power-on.
// - Data-not-ready clears and interrupt asserts within 2000 ms of power-on.
// - Fully functional once interrupt raised by data-not-ready clearing.
// - Low-power pin high enters power level 1 within 100 us.
// - Low-power pin low returns to full operation within 300 ms.
// - Any flag condition sets its flag and pulls interrupt low within 200 ms.
// - Receive loss of signal sets its flag and interrupt within 100 ms.
// - Transmit fault sets its flag and interrupt within 200 ms.
// - Flags clear on read; interrupt released within 500 us afterwards.
// - Setting a mask bit stops its interrupt within 100 ms.
// - Clearing a mask bit resumes its interrupt within 100 ms.
// - Rate select change settles bandwidth within 100 us.
// - Software power-down set enters power level 1 within 100 ms.
// - Software power-down cleared returns to full operation within 300 ms.
// - Write-triggered response times count from the end of that write.
// - Module answers two-wire address 1010000x only.
module mms_ctrl #(
	parameter logic [mms_pkg::CNT_W-1:0] INIT_CYC    = mms_pkg::CNT_W'(mms_pkg::INIT_CYC),
	parameter logic [mms_pkg::CNT_W-1:0] LP_ON_CYC   = mms_pkg::CNT_W'(mms_pkg::LP_ON_CYC),
	parameter logic [mms_pkg::CNT_W-1:0] LP_OFF_CYC  = mms_pkg::CNT_W'(mms_pkg::LP_OFF_CYC),
	parameter logic [mms_pkg::CNT_W-1:0] PD_ON_CYC   = mms_pkg::CNT_W'(mms_pkg::PD_ON_CYC),
	parameter logic [mms_pkg::CNT_W-1:0] PD_OFF_CYC  = mms_pkg::CNT_W'(mms_pkg::PD_OFF_CYC),
	parameter logic [mms_pkg::CNT_W-1:0] RATESEL_CYC = mms_pkg::CNT_W'(mms_pkg::RATESEL_CYC)
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        reset,
	// APB register port
	input  wire mms_pkg::mms_apb_req_t       apb_req,
	output var  mms_pkg::mms_apb_rsp_t       apb_rsp,
	// Module pins to and from the host
	input  wire logic                        reset_n_pin,
	input  wire logic                        low_power_pin,
	output logic                             interrupt_n_pin,
	// Two-wire management bus
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe,
	// Lane conditions from the optics
	input  wire logic [mms_pkg::LANES-1:0]   rx_los_in,
	input  wire logic [mms_pkg::LANES-1:0]   tx_fault_in,
	// Module state towards the optics and the system
	output logic                             irq,
	output logic                             power_low,
	output logic                             fully_functional,
	output logic [mms_pkg::RATE_W-1:0]       rate_applied
);
	import mms_pkg::*;

	// ==================================================================
	// Input synchronisers
	logic [1:0]       rstn_sync_q;
	logic [1:0]       lp_sync_q;
	logic [2:0]       scl_sync_q;
	logic [2:0]       sda_sync_q;
	logic [LANES-1:0] los_s1_q;
	logic [LANES-1:0] los_s2_q;
	logic [LANES-1:0] txf_s1_q;
	logic [LANES-1:0] txf_s2_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			rstn_sync_q <= 2'h3;
			lp_sync_q   <= 2'h0;
			scl_sync_q  <= 3'h7;
			sda_sync_q  <= 3'h7;
			los_s1_q    <= '0;
			los_s2_q    <= '0;
			txf_s1_q    <= '0;
			txf_s2_q    <= '0;
		end else begin
			rstn_sync_q <= {rstn_sync_q[0], reset_n_pin};
			lp_sync_q   <= {lp_sync_q[0], low_power_pin};
			scl_sync_q  <= {scl_sync_q[1:0], scl_in};
			sda_sync_q  <= {sda_sync_q[1:0], sda_in};
			los_s1_q    <= rx_los_in;
			los_s2_q    <= los_s1_q;
			txf_s1_q    <= tx_fault_in;
			txf_s2_q    <= txf_s1_q;
		end
	end

	// ==================================================================
	// Reset pin filter
	// Short glitches on the pin must not restart the module.
	logic [RST_CNT_W-1:0] rst_low_cnt_q;
	logic                 rst_request;

	assign rst_request = (rst_low_cnt_q == RST_CNT_W'(RESET_MIN_CYC));

	always_ff @(posedge clk) begin
		if (reset) begin
			rst_low_cnt_q <= '0;
		end else if (rstn_sync_q[1]) begin
			rst_low_cnt_q <= '0;
		end else if (!rst_request) begin
			rst_low_cnt_q <= rst_low_cnt_q + RST_CNT_W'(1);
		end
	end

	// ==================================================================
	// Initialisation sequencer
	typedef enum logic [1:0] {
		MMS_HOLD,
		MMS_INIT,
		MMS_READY
	} mms_init_t;

	mms_init_t        init_q;
	logic [CNT_W-1:0] init_cnt_q;
	logic             dnr_q;
	logic             init_done;
	logic             held;

	assign held      = (init_q == MMS_HOLD);
	assign init_done = (init_q == MMS_INIT) && (init_cnt_q == INIT_CYC - CNT_W'(1));

	always_ff @(posedge clk) begin
		if (reset) begin
			init_q     <= MMS_INIT;
			init_cnt_q <= '0;
			dnr_q      <= 1'b1;
		end else if (rst_request) begin
			init_q     <= MMS_HOLD;
			init_cnt_q <= '0;
			dnr_q      <= 1'b1;
		end else begin
			case (init_q)
				MMS_HOLD: begin
					// Sequence restarts at the rising edge of the pin
					if (rstn_sync_q[1]) begin
						init_q <= MMS_INIT;
					end
				end
				MMS_INIT: begin
					if (init_done) begin
						init_q <= MMS_READY;
						dnr_q  <= 1'b0;
					end else begin
						init_cnt_q <= init_cnt_q + CNT_W'(1);
					end
				end
				MMS_READY: begin
					init_cnt_q <= '0;
				end
				default: begin
					init_q <= MMS_INIT;
				end
			endcase
		end
	end

	// ==================================================================
	// APB slave
	logic        access;
	logic        wr_en;
	logic        rd_en;
	logic        sw_pdown_q;
	logic [RATE_W-1:0] rate_sel_q;
	logic [FLG_W-1:0]  flags_q;
	logic [FLG_W-1:0]  mask_q;
	logic [31:0]       status_word;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		if (a == ADDR_STATUS) begin
			return 1'b1;
		end else if (a == ADDR_FLAGS) begin
			return 1'b1;
		end else if (a == ADDR_MASK) begin
			return 1'b1;
		end else if (a == ADDR_CONTROL) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction : addr_mapped

	assign access = apb_req.psel && apb_req.penable && apb_rsp.pready;
	assign wr_en  = access && apb_req.pwrite && addr_mapped(apb_req.paddr);
	assign rd_en  = access && !apb_req.pwrite && addr_mapped(apb_req.paddr);

	always_comb begin
		status_word              = '0;
		status_word[ST_DNR]      = dnr_q;
		status_word[ST_FUNC]     = fully_functional;
		status_word[ST_LOWPWR]   = power_low;
		status_word[ST_RATEBUSY] = (rate_sel_q != rate_applied);
		status_word[ST_BUSRDY]   = !dnr_q;
	end

	// Ready is registered so every response signal leaves a flip-flop;
	// this gives exactly one access cycle per transfer.
	always_ff @(posedge clk) begin
		if (reset) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready <= apb_req.psel && !apb_req.penable;
			if (apb_req.psel && !apb_req.penable) begin
				apb_rsp.pslverr <= !addr_mapped(apb_req.paddr);
				if (apb_req.pwrite) begin
					apb_rsp.prdata <= '0;
				end else if (apb_req.paddr == ADDR_STATUS) begin
					apb_rsp.prdata <= status_word;
				end else if (apb_req.paddr == ADDR_FLAGS) begin
					apb_rsp.prdata <= 32'(flags_q);
				end else if (apb_req.paddr == ADDR_MASK) begin
					apb_rsp.prdata <= 32'(mask_q);
				end else if (apb_req.paddr == ADDR_CONTROL) begin
					apb_rsp.prdata <= 32'({rate_sel_q, sw_pdown_q});
				end else begin
					apb_rsp.prdata <= '0;
				end
			end
		end
	end

	// ==================================================================
	// Control and mask registers
	always_ff @(posedge clk) begin
		if (reset || held) begin
			sw_pdown_q <= 1'b0;
			rate_sel_q <= '0;
			mask_q     <= MASK_RST;
		end else if (wr_en) begin
			if (apb_req.paddr == ADDR_CONTROL) begin
				sw_pdown_q <= apb_req.pwdata[CTL_PDOWN];
				rate_sel_q <= apb_req.pwdata[CTL_RATE_LSB +: RATE_W];
			end else if (apb_req.paddr == ADDR_MASK) begin
				mask_q <= apb_req.pwdata[FLG_W-1:0];
			end
		end
	end

	// ==================================================================
	// Latched flags
	// A flag is cleared by the read that returns it, or by writing a one;
	// a condition still present sets it again in the same cycle.
	logic [FLG_W-1:0] flag_set;
	logic [FLG_W-1:0] flag_clr;
	logic [LANES-1:0] los_set;
	logic [LANES-1:0] txf_set;

	always_comb begin
		flag_set                       = '0;
		flag_set[FLG_READY]            = init_done;
		flag_set[FLG_LOS_LSB +: LANES] = los_set;
		flag_set[FLG_TXF_LSB +: LANES] = txf_set;
		flag_clr              = '0;
		if (rd_en && (apb_req.paddr == ADDR_FLAGS)) begin
			flag_clr = apb_rsp.prdata[FLG_W-1:0];
		end else if (wr_en && (apb_req.paddr == ADDR_FLAGS)) begin
			flag_clr = apb_req.pwdata[FLG_W-1:0];
		end
	end

	genvar ln;
	generate
		for (ln = 0; ln < LANES; ln++) begin : g_lane
			assign los_set[ln] = los_s2_q[ln] && !held;
			assign txf_set[ln] = txf_s2_q[ln] && !held;
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset || held) begin
			flags_q <= '0;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
		end
	end

	// ==================================================================
	// Interrupt outputs
	logic irq_d;

	assign irq_d = |(flags_q & ~mask_q);

	always_ff @(posedge clk) begin
		if (reset) begin
			irq             <= 1'b0;
			interrupt_n_pin <= 1'b1;
		end else begin
			irq             <= irq_d;
			interrupt_n_pin <= !irq_d;
		end
	end

	// ==================================================================
	// Power level control
	// Entry and exit both settle over a counted delay so that the optics
	// see a stable request; pin entry is far faster than software, and either exit takes the software exit count.
	logic             lp_target;
	logic [CNT_W-1:0] pwr_cnt_q;
	logic [CNT_W-1:0] pwr_limit;

	assign lp_target = lp_sync_q[1] || sw_pdown_q;

	always_comb begin
		if (power_low) begin
			pwr_limit = lp_sync_q[1] ? LP_OFF_CYC : PD_OFF_CYC;
		end else if (lp_sync_q[1]) begin
			pwr_limit = LP_ON_CYC;
		end else begin
			pwr_limit = PD_ON_CYC;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pwr_cnt_q <= '0;
			power_low <= 1'b0;
		end else if (lp_target == power_low) begin
			pwr_cnt_q <= '0;
		end else if (pwr_cnt_q >= pwr_limit - CNT_W'(1)) begin
			pwr_cnt_q <= '0;
			power_low <= lp_target;
		end else begin
			pwr_cnt_q <= pwr_cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fully_functional <= 1'b0;
		end else begin
			fully_functional <= (init_q == MMS_READY) && !power_low;
		end
	end

	// ==================================================================
	// Rate select settling
	logic [CNT_W-1:0] rate_cnt_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			rate_cnt_q   <= '0;
			rate_applied <= '0;
		end else if (rate_sel_q == rate_applied) begin
			rate_cnt_q <= '0;
		end else if (rate_cnt_q >= RATESEL_CYC - CNT_W'(1)) begin
			rate_cnt_q   <= '0;
			rate_applied <= rate_sel_q;
		end else begin
			rate_cnt_q <= rate_cnt_q + CNT_W'(1);
		end
	end

	// ==================================================================
	// Two-wire address recogniser
	// Only the address phase is answered here; data bytes are left to the
	// memory side and ignored by this block.
	typedef enum logic [1:0] {
		MMS_I_IDLE,
		MMS_I_ADDR,
		MMS_I_ACK,
		MMS_I_SKIP
	} mms_i2c_t;

	mms_i2c_t   i2c_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic       addr_done_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;

	assign scl_rise  = scl_sync_q[1] && !scl_sync_q[2];
	assign scl_fall  = !scl_sync_q[1] && scl_sync_q[2];
	assign bus_start = scl_sync_q[1] && scl_sync_q[2] && sda_sync_q[2] && !sda_sync_q[1];
	assign bus_stop  = scl_sync_q[1] && scl_sync_q[2] && !sda_sync_q[2] && sda_sync_q[1];

	always_ff @(posedge clk) begin
		if (reset) begin
			i2c_q       <= MMS_I_IDLE;
			bit_cnt_q   <= '0;
			shift_q     <= '0;
			addr_done_q <= 1'b0;
			sda_out     <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (bus_start) begin
			i2c_q       <= MMS_I_ADDR;
			bit_cnt_q   <= '0;
			addr_done_q <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (bus_stop) begin
			i2c_q  <= MMS_I_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (i2c_q)
				MMS_I_IDLE: begin
					sda_oe <= 1'b0;
				end
				MMS_I_ADDR: begin
					if (scl_rise) begin
						shift_q   <= {shift_q[6:0], sda_sync_q[1]};
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == LAST_BIT) begin
							addr_done_q <= 1'b1;
						end
					end else if (scl_fall && addr_done_q) begin
						// Silent until initialisation has finished
						if ((shift_q[7:1] == DEV_ADDR7) && !dnr_q) begin
							i2c_q  <= MMS_I_ACK;
							sda_oe <= 1'b1;
						end else begin
							i2c_q <= MMS_I_SKIP;
						end
					end
				end
				MMS_I_ACK: begin
					if (scl_fall) begin
						i2c_q  <= MMS_I_SKIP;
						sda_oe <= 1'b0;
					end
				end
				MMS_I_SKIP: begin
					sda_oe <= 1'b0;
				end
				default: begin
					i2c_q <= MMS_I_IDLE;
				end
			endcase
		end
	end

endmodule : mms_ctrl

`default_nettype wire

//--- testbench/mms_ctrl_chk.sv
// Concurrent checks on the management controller ports
`timescale 1ns/1ns
`default_nettype none
module mms_ctrl_chk #(
	parameter int LP_ON_CYC   = 10,
	parameter int PD_ON_CYC   = 10,
	parameter int RATESEL_CYC = 10
) (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  reset,
	// Register port
	input wire mms_pkg::mms_apb_req_t apb_req,
	input wire mms_pkg::mms_apb_rsp_t apb_rsp,
	// Pins and lane conditions
	input wire logic                  low_power_pin,
	input wire logic                  interrupt_n_pin,
	input wire logic [3:0]            rx_los_in,
	input wire logic [3:0]            tx_fault_in,
	// Module state
	input wire logic                  irq,
	input wire logic                  power_low,
	input wire logic [3:0]            rate_applied
);
	import mms_pkg::*;
	// Bounds allow for the two synchroniser stages and the output register
	localparam int LP_B = LP_ON_CYC + 6;
	localparam int PD_B = PD_ON_CYC + 4;
	localparam int RT_B = RATESEL_CYC + 4;
	logic [8:0] mask_q;
	logic [3:0] rate_q;
	wire logic  acc   = apb_req.psel & apb_req.penable & apb_rsp.pready;
	wire logic  wr    = acc & apb_req.pwrite;
	wire logic  rd_fl = acc & !apb_req.pwrite & (apb_req.paddr == ADDR_FLAGS);
	wire logic  wr_ct = wr & (apb_req.paddr == ADDR_CONTROL);

	// ==========
	// Shadow of written mask and rate; a pin reset leaves them stale, so
	// the rate and full-mask checks only fire on fresh writes
	always_ff @(posedge clk) begin
		if (reset)
			mask_q <= MASK_RST;
		else if (wr && apb_req.paddr == ADDR_MASK)
			mask_q <= apb_req.pwdata[8:0];
	end
	always_ff @(posedge clk) begin
		if (reset)
			rate_q <= 4'h0;
		else if (wr_ct)
			rate_q <= apb_req.pwdata[4:1];
	end

	// ==========
	// Assertions
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (reset);

	pin_mirror_a: assert property (interrupt_n_pin != irq)
		else $error("interrupt pin and irq disagree");
	los_irq_a: assert property ($rose(|(rx_los_in & ~mask_q[4:1])) |-> ##[1:6] irq)
		else $error("loss of signal raised no interrupt");
	txf_irq_a: assert property ($rose(|(tx_fault_in & ~mask_q[8:5])) |-> ##[1:6] irq)
		else $error("transmit fault raised no interrupt");
	mask_quiet_a: assert property (wr && apb_req.paddr == ADDR_MASK &&
		apb_req.pwdata[8:0] == 9'h1FF |-> ##[1:3] !irq)
		else $error("full mask left interrupt asserted");
	lp_enter_a: assert property ($rose(low_power_pin) |-> ##[1:LP_B] power_low)
		else $error("low power pin not obeyed in time");
	pd_enter_a: assert property (wr_ct && apb_req.pwdata[0] |-> ##[1:PD_B] power_low)
		else $error("power down bit not obeyed in time");
	rate_set_a: assert property ($changed(rate_q) |-> ##[1:RT_B] rate_applied == rate_q)
		else $error("rate select did not settle in time");
	read_clear_a: assert property (rd_fl && rx_los_in == 4'h0 &&
		tx_fault_in == 4'h0 |-> ##[1:3] !irq)
		else $error("flag read did not release interrupt");

	cover property ($rose(irq) ##[1:20] $fell(irq));
	cover property ($rose(power_low));
	cover property ($changed(rate_applied));
endmodule : mms_ctrl_chk

bind mms_ctrl mms_ctrl_chk #(
	.LP_ON_CYC(LP_ON_CYC), .PD_ON_CYC(PD_ON_CYC), .RATESEL_CYC(RATESEL_CYC)
) mms_ctrl_chk_i (
	.clk, .reset, .apb_req, .apb_rsp, .low_power_pin, .interrupt_n_pin,
	.rx_los_in, .tx_fault_in, .irq, .power_low, .rate_applied
);
`default_nettype wire

//--- testbench/mms_host.sv
// Host model on the two-wire management bus
`timescale 1ns/1ns
`default_nettype none
module mms_host (
	// Two-wire lines; both rest high between frames, sda through a pull-up
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// START, one address byte, sample of the ninth bit, STOP
	task automatic send_addr(input logic [7:0] b, output logic ack);
		sda_low = 1'b1;
		#80 scl = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			#40 sda_low = !b[i];
			#40 scl = 1'b1;
			#80 scl = 1'b0;
		end
		#40 sda_low = 1'b0;
		#40 scl = 1'b1;
		ack = !sda;
		#80 scl = 1'b0;
		#40 sda_low = 1'b1;
		#40 scl = 1'b1;
		#80 sda_low = 1'b0;
		// Bus free time, so that a following START is seen apart from this STOP
		#80;
	endtask : send_addr
endmodule : mms_host
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench of the management controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import mms_pkg::*;
	logic         clk = 1'b0;
	logic         reset = 1'b1;
	mms_apb_req_t req = '0;
	mms_apb_rsp_t rsp;
	logic         reset_n_pin = 1'b1;
	logic         low_power_pin = 1'b0;
	logic [3:0]   los = 4'h0;
	logic [3:0]   txf = 4'h0;
	logic [3:0]   rate, v, r;
	logic         irq, pl, ff, oe, so, inn, scl, hl, ack, err;
	logic [31:0]  rd;
	logic [7:0]   adr [4] = '{8'hA0, 8'hA1, 8'hA2, 8'h20};
	int           num_errors = 0;
	int           n_checks = 0;
	// Open-drain line with pull-up: low while either party pulls it
	wire logic    sda = !(oe | hl);

	always #5 clk = !clk;

	// Every exit from low power here is timed by the software exit count
	mms_ctrl #(.INIT_CYC(28'h32), .LP_ON_CYC(28'hA),
		.PD_ON_CYC(28'hA), .PD_OFF_CYC(28'h14), .RATESEL_CYC(28'hA)) mms_ctrl_i (
		.clk, .reset, .apb_req(req), .apb_rsp(rsp), .reset_n_pin, .low_power_pin,
		.interrupt_n_pin(inn), .scl_in(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe),
		.rx_los_in(los), .tx_fault_in(txf), .irq, .power_low(pl),
		.fully_functional(ff), .rate_applied(rate));
	mms_host mms_host_i (.scl, .sda_low(hl), .sda);

	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge clk);
	endtask : apb
	task automatic give_verdict;
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	// ==========
	// Scenarios
	initial begin
		void'($urandom(1));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h1);
		repeat (60) @(posedge clk);
		chk(irq, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h2);
		apb(1'b0, ADDR_FLAGS, 32'h0);
		chk(rd, 32'h1);
		repeat (3) @(posedge clk);
		chk(irq, 32'h0);
		foreach (adr[i]) begin
			mms_host_i.send_addr(adr[i], ack);
			chk(ack, 32'(adr[i][7:1] == 7'h50));
		end
		chk(so, 32'h0);
		@(posedge clk);
		for (int k = 0; k < 2; k++) begin
			v = 4'($urandom_range(15, 1));
			if (k == 0) los <= v;
			else txf <= v;
			repeat (6) @(posedge clk);
			chk(inn, 32'h0);
			los <= 4'h0;
			txf <= 4'h0;
			repeat (4) @(posedge clk);
			chk(irq, 32'h1);
			apb(1'b0, ADDR_FLAGS, 32'h0);
			chk(rd, 32'(v) << (k == 0 ? FLG_LOS_LSB : FLG_TXF_LSB));
			repeat (2) @(posedge clk);
			chk(irq, 32'h0);
		end
		apb(1'b1, ADDR_MASK, 32'h1FF);
		los <= 4'hF;
		repeat (6) @(posedge clk);
		chk(irq, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 32'h1);
		los <= 4'h0;
		repeat (4) @(posedge clk);
		apb(1'b0, ADDR_FLAGS, 32'h0);
		chk(rd, 32'h1E);
		low_power_pin <= 1'b1;
		repeat (16) @(posedge clk);
		chk({pl, ff}, 32'h2);
		low_power_pin <= 1'b0;
		repeat (26) @(posedge clk);
		chk({pl, ff}, 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h1);
		repeat (15) @(posedge clk);
		chk(pl, 32'h1);
		apb(1'b1, ADDR_CONTROL, 32'h0);
		repeat (25) @(posedge clk);
		chk(pl, 32'h0);
		r = 4'($urandom_range(15, 1));
		apb(1'b1, ADDR_CONTROL, 32'(r) << 1);
		repeat (14) @(posedge clk);
		chk(rate, 32'(r));
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		// A pulse shorter than the minimum must leave the module running
		reset_n_pin <= 1'b0;
		repeat (50) @(posedge clk);
		reset_n_pin <= 1'b1;
		repeat (5) @(posedge clk);
		chk(ff, 32'h1);
		reset_n_pin <= 1'b0;
		repeat (250) @(posedge clk);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h3, 32'h1);
		// No answer on the bus while data is not ready
		mms_host_i.send_addr(8'hA0, ack);
		chk(ack, 32'h0);
		@(posedge clk);
		reset_n_pin <= 1'b1;
		repeat (60) @(posedge clk);
		chk({ff, irq}, 32'h3);
		give_verdict;
	end

	initial begin
		#200000;
		num_errors++;
		give_verdict;
	end
endmodule : testbench
`default_nettype wire
